// *** hdl/emc_mode_config.sv ***
// Energy meter mode and output configuration register bank
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Operation
// - Writing bit 7 resets measurement registers
// - Bit 6 bypasses zero-cross low-pass filter
// - Bit 4 swaps ADC channels
// - Bit 3 powers down both ADCs
// - Bit 2 resets one, disables output B
// - Bit 1 resets one, disables output A
// - Bit 0 bypasses channel high-pass filters
// - Output B source, reset 01
// - Output A source, reset 00
// - Bit 3 picks apparent power or rms
// - Bit 2 syncs rms updates to zero-cross
// - Bit 1 selects period or frequency
// - Bit 0 enables waveform sampling
module emc_mode_config
    import emc_pkg::*;
#(
    parameter int ADDR_W = 7
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // Configuration to the datapath
    output emc_cfg_t cfg
);
    // Elaboration check on address width
    if (ADDR_W < 7) begin : g_chk
        $error("ADDR_W must be at least 7");
    end

    // All state of the block
    typedef struct packed {
        logic [7:0] modeA;
        logic [7:0] outCfg;
        logic softRst;
        logic [7:0] rdData;
    } emc_state_t;

    emc_state_t st_r; // Registered state
    emc_state_t st_nxt; // Next state
    emc_src_t qB; // Decoded output B quantity
    emc_src_t qA; // Decoded output A quantity

    // Address match helper
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [6:0] offs);
        hit = (a == ADDR_W'(offs));
    endfunction : hit

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.softRst = 1'b0;
        // Soft reset bit never stored, reads back zero
        st_nxt.modeA[SOFT_RESET_BIT] = 1'b0;
        if (st_r.softRst) begin
            // Register defaults restored after soft reset
            st_nxt.modeA = MODE_A_RESET;
            st_nxt.outCfg = OUT_CFG_RESET;
        end
        if (regWrStb) begin
            if (hit(regAddr, MODE_A_OFFS)) begin
                // Store bits; bit 5 stored as written, software keeps 0
                st_nxt.modeA = regWrData;
                st_nxt.modeA[SOFT_RESET_BIT] = 1'b0;
                st_nxt.softRst = regWrData[SOFT_RESET_BIT];
            end else if (hit(regAddr, OUT_CFG_OFFS)) begin
                st_nxt.outCfg = regWrData;
            end
        end
        // Read data stands one cycle after the strobe
        st_nxt.rdData = 8'h00;
        if (regRdStb) begin
            if (hit(regAddr, MODE_A_OFFS)) begin
                st_nxt.rdData = st_nxt.modeA;
            end else if (hit(regAddr, OUT_CFG_OFFS)) begin
                st_nxt.rdData = st_nxt.outCfg;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= '{modeA: MODE_A_RESET, outCfg: OUT_CFG_RESET,
                      softRst: 1'b0, rdData: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Source decoders for both pulse outputs
    emc_src_decode u_decB (
        .srcCode(st_r.outCfg[PULSE_B_SRC_LSB +: 2]),
        .appOrRms(st_r.outCfg[APP_RMS_SEL_BIT]),
        .quantity(qB)
    );
    emc_src_decode u_decA (
        .srcCode(st_r.outCfg[PULSE_A_SRC_LSB +: 2]),
        .appOrRms(st_r.outCfg[APP_RMS_SEL_BIT]),
        .quantity(qA)
    );

    // Outputs
    assign regRdData = st_r.rdData;
    always_comb begin
        cfg.measRegReset = st_r.softRst;
        cfg.zeroCrossFilterDisable = st_r.modeA[ZX_FILT_DIS_BIT];
        cfg.channelSwap = st_r.modeA[CH_SWAP_BIT];
        cfg.adcPowerDown = st_r.modeA[ADC_PDN_BIT];
        cfg.pulseOutBEnable = ~st_r.modeA[PULSE_B_DIS_BIT];
        cfg.pulseOutAEnable = ~st_r.modeA[PULSE_A_DIS_BIT];
        cfg.highpassBypass = st_r.modeA[HPF_BYP_BIT];
        cfg.pulseOutBQuantity = qB;
        cfg.pulseOutAQuantity = qA;
        cfg.apparentAccumRms = st_r.outCfg[APP_RMS_SEL_BIT];
        cfg.rmsZeroCrossSync = st_r.outCfg[RMS_ZX_BIT];
        cfg.periodFrequencySelect = st_r.outCfg[LINE_PERIOD_FREQUENCY_BIT];
        cfg.waveformSamplingEnable = st_r.outCfg[WAVE_EN_BIT];
    end
endmodule : emc_mode_config

// *** hdl/emc_pkg.sv ***
// Package of register map, field layout and decoded config types
package emc_pkg;
    // Register offsets
    localparam logic [6:0] MODE_A_OFFS = 7'h0B;
    localparam logic [6:0] OUT_CFG_OFFS = 7'h0C;
    // Reset values
    localparam logic [7:0] MODE_A_RESET = 8'h06;
    localparam logic [7:0] OUT_CFG_RESET = 8'h40;
    // Field positions, mode register A
    localparam int SOFT_RESET_BIT = 7;
    localparam int ZX_FILT_DIS_BIT = 6;
    localparam int RESV_BIT = 5;
    localparam int CH_SWAP_BIT = 4;
    localparam int ADC_PDN_BIT = 3;
    localparam int PULSE_B_DIS_BIT = 2;
    localparam int PULSE_A_DIS_BIT = 1;
    localparam int HPF_BYP_BIT = 0;
    // Field positions, output configuration register
    localparam int PULSE_B_SRC_LSB = 6;
    localparam int PULSE_A_SRC_LSB = 4;
    localparam int APP_RMS_SEL_BIT = 3;
    localparam int RMS_ZX_BIT = 2;
    localparam int LINE_PERIOD_FREQUENCY_BIT = 1;
    localparam int WAVE_EN_BIT = 0;
    // Soft reset pulse length in core cycles
    localparam int SOFT_RESET_CYCLES = 1;

    // Quantity a pulse output follows
    typedef enum logic [1:0] {
        EMC_SRC_ACTIVE = 2'h0,
        EMC_SRC_REACTIVE = 2'h1,
        EMC_SRC_APPARENT = 2'h2,
        EMC_SRC_RMS_CUR = 2'h3
    } emc_src_t;

    // Decoded configuration to the datapath
    typedef struct packed {
        logic measRegReset;
        logic zeroCrossFilterDisable;
        logic channelSwap;
        logic adcPowerDown;
        logic pulseOutBEnable;
        logic pulseOutAEnable;
        logic highpassBypass;
        emc_src_t pulseOutBQuantity;
        emc_src_t pulseOutAQuantity;
        logic apparentAccumRms;
        logic rmsZeroCrossSync;
        logic periodFrequencySelect;
        logic waveformSamplingEnable;
    } emc_cfg_t;
endpackage : emc_pkg

// *** hdl/emc_src_decode.sv ***
// Pulse output source decoder
`timescale 1ns/1ps
module emc_src_decode
    import emc_pkg::*;
(
    // Field inputs
    input wire logic [1:0] srcCode,
    input wire logic appOrRms,
    // Decoded quantity
    output emc_src_t quantity
);
    // 1x picks apparent power or rms current by the select bit
    always_comb begin
        unique case (srcCode)
            2'h0: quantity = EMC_SRC_ACTIVE;
            2'h1: quantity = EMC_SRC_REACTIVE;
            default: quantity = appOrRms ? EMC_SRC_RMS_CUR
                                         : EMC_SRC_APPARENT;
        endcase
    end
endmodule : emc_src_decode

// *** bench/emc_checker.sv ***
// Concurrent checks on the mode config register bank ports
`timescale 1ns/1ps
module emc_checker
    import emc_pkg::*;
#(parameter int ADDR_W = 7) (
    // Clock and reset
    input logic ref_clk,
    input logic rst,
    // Register port
    input logic [ADDR_W-1:0] regAddr,
    input logic [7:0] regWrData,
    input logic regWrStb,
    input logic regRdStb,
    input logic [7:0] regRdData,
    // Decoded config
    input emc_cfg_t cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Writes that land, outside a soft reset pulse for C
    wire wA = regWrStb && regAddr == MODE_A_OFFS;
    wire wC = regWrStb && regAddr == OUT_CFG_OFFS && !cfg.measRegReset;
    wire [7:0] d = regWrData;
    soft_pulse_a: assert property (wA && d[7] ##1 !regWrStb |->
        cfg.measRegReset ##1 (!cfg.measRegReset && !cfg.pulseOutAEnable
        && cfg.pulseOutBQuantity == EMC_SRC_REACTIVE)) else $error("soft");
    no_pulse_a: assert property (!(wA && d[7]) |=> !cfg.measRegReset)
        else $error("stray pulse");
    mode_bits_a: assert property (wA && !d[7] |=> {cfg.zeroCrossFilterDisable,
        cfg.channelSwap, cfg.adcPowerDown, cfg.highpassBypass} ==
        $past({d[6], d[4], d[3], d[0]})) else $error("mode bits");
    out_dis_a: assert property (wA && !d[7] |=> {cfg.pulseOutBEnable,
        cfg.pulseOutAEnable} == ~$past(d[2:1])) else $error("disables");
    src_b_a: assert property (wC |=> cfg.pulseOutBQuantity ==
        $past(d[7] ? {1'b1, d[3]} : d[7:6])) else $error("source B");
    src_a_a: assert property (wC |=> cfg.pulseOutAQuantity ==
        $past(d[5] ? {1'b1, d[3]} : d[5:4])) else $error("source A");
    misc_bits_a: assert property (wC |=> {cfg.apparentAccumRms,
        cfg.rmsZeroCrossSync, cfg.periodFrequencySelect,
        cfg.waveformSamplingEnable} == $past(d[3:0])) else $error("misc");
    unmapped_rd_a: assert property (regRdStb && regAddr != MODE_A_OFFS &&
        regAddr != OUT_CFG_OFFS |=> regRdData == 8'h00) else $error("unmapped");
    rd_idle_a: assert property (!regRdStb |=> regRdData == 8'h00)
        else $error("idle read");
    cover property (wA && d[7]);
    cover property (wC && d[7] && d[3]);
    cover property (regRdStb ##1 regRdData != 8'h00);
endmodule : emc_checker
bind emc_mode_config emc_checker #(.ADDR_W(ADDR_W)) chkI (.ref_clk(ref_clk),
    .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .cfg(cfg));

// *** bench/tb_top.sv ***
// Random and corner tests of the mode config register bank
`timescale 1ns/1ps
module tb_top;
    import emc_pkg::*;
    logic ref_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0;
    logic [6:0] regAddr = '0, a;
    logic [7:0] regWrData = '0, regRdData, mA, mC, d, e;
    logic [31:0] s = 90, r;
    emc_cfg_t cfg;
    int badCount = 0, nTests = 0, cyc = 0;
    emc_mode_config DUT (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .cfg(cfg));
    always #2.5 ref_clk = ~ref_clk;
    function logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Source code 1x picks apparent or rms
    function logic [1:0] q(input logic [1:0] c, input logic f);
        return c[1] ? {1'b1, f} : c;
    endfunction : q
    function emc_cfg_t ec(input logic [7:0] x, input logic [7:0] c);
        return {1'b0, x[6], x[4], x[3], ~x[2:1], x[0], q(c[7:6], c[3]),
            q(c[5:4], c[3]), c[3:0]};
    endfunction : ec
    task chk(input logic [15:0] v, input logic [15:0] x);
        nTests++;
        if (v !== x) begin
            badCount++;
            $display("ERROR %0t: got %h want %h", $time, v, x);
        end
    endtask : chk
    task wr(input logic [6:0] ad, input logic [7:0] v);
        regWrStb <= 1;
        regAddr <= ad;
        regWrData <= v;
        @(posedge ref_clk);
        regWrStb <= 0;
    endtask : wr
    task rd(input logic [6:0] ad, input logic [7:0] x);
        regRdStb <= 1;
        regAddr <= ad;
        @(posedge ref_clk);
        regRdStb <= 0;
        #1 chk(regRdData, x);
    endtask : rd
    task finalReport();
        $display("Mismatches %0d of %0d checks", badCount, nTests);
        if (badCount == 0 && nTests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finalReport
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            badCount++;
            finalReport();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        rd(MODE_A_OFFS, 8'h06);
        rd(OUT_CFG_OFFS, 8'h40);
        mA = 8'h06;
        mC = 8'h40;
        // Write then read back at once, unmapped 0x0D among them
        for (int i = 0; i < 80; i++) begin
            r = xs();
            d = r[15:8];
            a = r[1:0] == 0 ? 7'h0D : r[0] ? MODE_A_OFFS : OUT_CFG_OFFS;
            if (a == MODE_A_OFFS) d = d & 8'h5F;
            if (a == MODE_A_OFFS) mA = d;
            if (a == OUT_CFG_OFFS) mC = d;
            e = a == MODE_A_OFFS ? mA : a == OUT_CFG_OFFS ? mC : 8'h00;
            wr(a, d);
            rd(a, e);
            chk(cfg, ec(mA, mC));
        end
        // Soft reset with other bits set
        wr(MODE_A_OFFS, 8'h9B);
        #1 chk(cfg.measRegReset, 1'b1);
        @(posedge ref_clk);
        #1 chk(cfg, ec(8'h06, 8'h40));
        rd(MODE_A_OFFS, 8'h06);
        finalReport();
    end
endmodule : tb_top
